// ### rtl/sram_host_pkg.sv
// Notes on behaviour
// [RQ1] Write stores each byte whose select is low.
// [RQ2] Read drives each byte whose select is low.
// [RQ3] Standby when deselected or both selects high; the standby output ignores the byte selects.
// [RQ4] Data pins float unless reading enabled lanes.
// [RQ5] Write lasts while select and strobe overlap.
// [RQ6] Host holds data relative to ending edge.
// [RQ7] Simultaneous rise keeps memory outputs floating.
// [RQ8] Output enable high keeps pins floating during writes.
// [RQ9] Host never drives while memory still drives.
// [RQ10] Strobe write lasts float delay plus data lead.
// [RQ11] Host holds write strobe high during reads.
// [RQ12] Address valid no later than select falling.
// [RQ13] Power-down within 70 ns of deselect.
// [RQ14] Both selects falling: drive after 10 ns.
// [RQ15] Both selects high: no store, pins float.
package sram_host_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 10;

  // Timing figures in nanoseconds.
  localparam int READ_CYCLE_NS = 70;
  localparam int STROBE_LOW_TO_FLOAT_DELAY_NS = 35;
  localparam int WRITE_DATA_LEAD_TIME_NS = 30;
  localparam int WRITE_PULSE_NS = 60;
  localparam int DESELECT_TO_POWERDOWN_DELAY_NS = 70;
  localparam int BYTE_SELECT_TO_DRIVE_DELAY_NS = 10;

  // Least times round up to whole cycles.
  localparam int READ_CYC =
    (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC =
    (STROBE_LOW_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_CYC =
    (WRITE_DATA_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (FLOAT_CYC + LEAD_CYC > PULSE_CYC) ?
    FLOAT_CYC + LEAD_CYC : PULSE_CYC;
  localparam int POWERDOWN_CYC =
    (DESELECT_TO_POWERDOWN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = 1;
  localparam int CNT_W = 4;

  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  localparam logic [17:0] ADDR_ZERO = 18'h00000;

  // Request from the user side.
  typedef struct packed {
    logic write;
    logic [1:0] laneEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sram_req_t;

  // Pins toward the memory, all active low except the address.
  typedef struct packed {
    logic chipSel_n;
    logic writeStrobe_n;
    logic outDrive_n;
    logic upper_byte_select_n;
    logic lower_byte_select_n;
    logic [ADDR_W-1:0] addr;
  } sram_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_WSETUP, ST_WRITE, ST_RECOVER
  } sram_state_t;

endpackage : sram_host_pkg

// ### rtl/sram_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reqValid,
  output logic reqReady,
  input wire sram_host_pkg::sram_req_t req,
  output logic rspValid,
  output logic [15:0] rspData,
  output sram_host_pkg::sram_pins_t pins,
  input wire logic [15:0] dqIn,
  output logic [15:0] dqOut,
  output logic [15:0] dqOe,
  output logic standby
);

  ////////////////////////////////////////////////////////////////////////
  sram_host_pkg::sram_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  sram_host_pkg::sram_pins_t pins_reg, pins_next;
  logic [15:0] dqOut_reg, dqOut_next;
  logic [15:0] dqOe_reg, dqOe_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rspValid_reg, rspValid_next;
  logic [3:0] idle_reg, idle_next;
  logic [15:0] dqSync1_reg, dqSync2_reg;
  logic [15:0] selMask;
  logic takeReq;
  logic readDone;
  logic writeDone;
  logic accessEnd;

  // Read data crosses two flip-flops before use.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dqSync1_reg <= sram_host_pkg::DATA_ZERO;
      dqSync2_reg <= sram_host_pkg::DATA_ZERO;
    end else begin
      dqSync1_reg <= dqIn;
      dqSync2_reg <= dqSync1_reg;
    end
  end

  // Lanes whose byte select stands low at the pins.
  assign selMask = {{8{~pins_reg.upper_byte_select_n}},
                    {8{~pins_reg.lower_byte_select_n}}};

  // Events of the sequencer that the other groups follow.
  assign takeReq = (state_reg == sram_host_pkg::ST_IDLE) && reqValid;
  assign readDone = (state_reg == sram_host_pkg::ST_READ) &&
                    (cnt_reg == 4'h1);
  assign writeDone = (state_reg == sram_host_pkg::ST_WRITE) &&
                     (cnt_reg == 4'h1);
  assign accessEnd = (state_reg == sram_host_pkg::ST_RECOVER) &&
                     (cnt_reg == 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer computes the next pin levels and counts.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pins_next = pins_reg;
    case (state_reg)
      sram_host_pkg::ST_IDLE: begin
        if (reqValid) begin
          // Address and byte selects set up with select falling.
          pins_next.addr = req.addr; // RQ12
          pins_next.chipSel_n = 1'b0;
          pins_next.upper_byte_select_n = ~req.laneEn[1]; // RQ1
          pins_next.lower_byte_select_n = ~req.laneEn[0]; // RQ2
          pins_next.writeStrobe_n = 1'b1; // RQ11
          if (req.write) begin
            pins_next.outDrive_n = 1'b1; // RQ8
            state_next = sram_host_pkg::ST_WSETUP;
          end else begin
            pins_next.outDrive_n = 1'b0;
            cnt_next = 4'(sram_host_pkg::READ_CYC);
            state_next = sram_host_pkg::ST_READ;
          end
        end
      end
      sram_host_pkg::ST_READ: begin
        cnt_next = cnt_reg - 4'h1;
        if (readDone) begin
          pins_next.chipSel_n = 1'b1;
          pins_next.outDrive_n = 1'b1;
          cnt_next = 4'(sram_host_pkg::RECOVER_CYC);
          state_next = sram_host_pkg::ST_RECOVER;
        end
      end
      sram_host_pkg::ST_WSETUP: begin
        // Strobe falls in the cycle in which the host starts to drive.
        pins_next.writeStrobe_n = 1'b0; // RQ5
        cnt_next = 4'(sram_host_pkg::WRITE_CYC); // RQ10
        state_next = sram_host_pkg::ST_WRITE;
      end
      sram_host_pkg::ST_WRITE: begin
        cnt_next = cnt_reg - 4'h1;
        if (writeDone) begin
          // Strobe rises first; data held one more cycle past it.
          pins_next.writeStrobe_n = 1'b1; // RQ6
          cnt_next = 4'(sram_host_pkg::RECOVER_CYC);
          state_next = sram_host_pkg::ST_RECOVER;
        end
      end
      sram_host_pkg::ST_RECOVER: begin
        cnt_next = cnt_reg - 4'h1;
        if (accessEnd) begin
          pins_next.chipSel_n = 1'b1;
          pins_next.outDrive_n = 1'b1;
          state_next = sram_host_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = sram_host_pkg::ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= sram_host_pkg::ST_IDLE;
      cnt_reg <= sram_host_pkg::CNT_ZERO;
      pins_reg <= '{chipSel_n: 1'b1, writeStrobe_n: 1'b1,
                    outDrive_n: 1'b1, upper_byte_select_n: 1'b1,
                    lower_byte_select_n: 1'b1,
                    addr: sram_host_pkg::ADDR_ZERO};
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pins_reg <= pins_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write data is taken with the request and driven until deselect.
  always_comb begin
    dqOut_next = dqOut_reg;
    dqOe_next = dqOe_reg;
    if (takeReq && req.write) begin
      dqOut_next = req.wdata;
    end
    if (state_reg == sram_host_pkg::ST_WSETUP) begin
      // Memory outputs are already off, so only selected lanes drive.
      dqOe_next = selMask; // RQ9
    end else if (accessEnd) begin
      dqOe_next = sram_host_pkg::DATA_ZERO;
    end
  end

  // Registers of the write data path.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dqOut_reg <= sram_host_pkg::DATA_ZERO;
      dqOe_reg <= sram_host_pkg::DATA_ZERO;
    end else begin
      dqOut_reg <= dqOut_next;
      dqOe_reg <= dqOe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data keeps only the enabled lanes; valid pulses once an access.
  always_comb begin
    rdata_next = rdata_reg;
    rspValid_next = 1'b0;
    if (readDone) begin
      rdata_next = dqSync2_reg & selMask;
      rspValid_next = 1'b1;
    end
    if (writeDone) begin
      rspValid_next = 1'b1;
    end
  end

  // Registers of the response.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= sram_host_pkg::DATA_ZERO;
      rspValid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rspValid_reg <= rspValid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-down timer, restarted whenever an access leaves the recovery state.
  always_comb begin
    idle_next = idle_reg;
    if (accessEnd) begin
      idle_next = 4'(sram_host_pkg::POWERDOWN_CYC); // RQ13
    end else if ((state_reg == sram_host_pkg::ST_IDLE) &&
                 (idle_reg != sram_host_pkg::CNT_ZERO)) begin
      idle_next = idle_reg - 4'h1;
    end
  end

  // Register of the power-down timer.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idle_reg <= sram_host_pkg::CNT_ZERO;
    end else begin
      idle_reg <= idle_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; standby shows the memory has reached power-down.
  assign reqReady = (state_reg == sram_host_pkg::ST_IDLE);
  assign rspValid = rspValid_reg;
  assign rspData = rdata_reg;
  assign pins = pins_reg;
  assign dqOut = dqOut_reg;
  assign dqOe = dqOe_reg;
  assign standby = (state_reg == sram_host_pkg::ST_IDLE) &&
                   (idle_reg == sram_host_pkg::CNT_ZERO); // RQ3

endmodule : sram_host_ctrl
`default_nettype wire

// ### verif/sram_props.sv
`timescale 1ns/1ps
`default_nettype none
module sram_props (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire sram_host_pkg::sram_req_t req,
  input wire logic rspValid,
  input wire sram_host_pkg::sram_pins_t pins,
  input wire logic [15:0] dqOe,
  input wire logic standby
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Marks the edge at which a read is taken.
  wire rd = reqValid && reqReady && !req.write;
  // Each property ties a pin to its cause.
  rd_answer_a: assert property (rd |-> ##8 rspValid)
    else $error("Late read.");
  rd_strobe_a: assert property (rd |=> pins.writeStrobe_n [*8])
    else $error("Strobe low.");
  wr_len_a: assert property ($fell(pins.writeStrobe_n) |->
    !pins.writeStrobe_n [*7] ##1 pins.writeStrobe_n) else $error("Pulse.");
  wr_end_a: assert property ($rose(pins.writeStrobe_n) |->
    !pins.chipSel_n) else $error("End edge.");
  host_drive_a: assert property (|dqOe |-> pins.outDrive_n)
    else $error("Clash.");
  addr_hold_a: assert property (!pins.chipSel_n &&
    !$past(pins.chipSel_n) |-> $stable(pins.addr)) else $error("Addr.");
  sel_active_a: assert property (!pins.chipSel_n |-> !standby)
    else $error("Standby.");
  standby_late_a: assert property ($rose(standby) |->
    $past(pins.chipSel_n, 7)) else $error("Early standby.");
  wr_hold_a: assert property ($rose(pins.writeStrobe_n) |->
    $stable(dqOe) ##1 (dqOe == 16'h0000)) else $error("Data hold.");
endmodule : sram_props
bind sram_host_ctrl sram_props u_props (.clk_sys(clk_sys), .nrst(nrst),
  .reqValid(reqValid), .reqReady(reqReady), .req(req),
  .rspValid(rspValid), .pins(pins), .dqOe(dqOe), .standby(standby));
`default_nettype wire

// ### verif/sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  input wire sram_host_pkg::sram_pins_t pins,
  input wire logic [15:0] hData,
  input wire logic [15:0] hEn,
  output logic [15:0] dq
);
  logic [15:0] mem [0:262143];
  logic [15:0] lane, drv;
  logic wr = 1'b0;
  // Lanes enabled by the active-low byte selects.
  assign lane = {{8{!pins.upper_byte_select_n}},
    {8{!pins.lower_byte_select_n}}};
  // A write lasts while select and strobe are low and stores at its end.
  always @(pins) begin
    if (wr && (pins.chipSel_n || pins.writeStrobe_n))
      mem[pins.addr] = mem[pins.addr] & ~lane |
        (hEn & hData | ~hEn & ~hData) & lane;
    wr = !pins.chipSel_n && !pins.writeStrobe_n;
  end
  // Lanes drive only in a read, 10 ns after selection.
  assign #10 drv = lane & {16{!pins.chipSel_n &&
    pins.writeStrobe_n && !pins.outDrive_n}};
  // Undriven bits show the inverse of the host data.
  assign dq = hEn & hData | ~hEn & (drv & mem[pins.addr] | ~drv & ~hData);
endmodule : sram_model
`default_nettype wire

// ### verif/async_sram_byte_lane_access_test.sv
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_lane_access_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b1;
  logic reqValid = 1'b0;
  logic reqReady, rspValid, standby;
  sram_host_pkg::sram_req_t req = '0;
  sram_host_pkg::sram_pins_t pins;
  logic [15:0] rspData, dqIn, dqOut, dqOe;
  int num_errors, comparisons;
  // The controller drives a behavioural memory.
  sram_host_ctrl u_sram_host_ctrl (.clk_sys(clk_sys), .nrst(nrst),
    .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .rspValid(rspValid), .rspData(rspData), .pins(pins), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .standby(standby));
  sram_model u_sram_model (.pins(pins), .hData(dqOut), .hEn(dqOe),
    .dq(dqIn));
  // Clock.
  initial forever #5 clk_sys = ~clk_sys;
  // Run limit.
  initial begin
    repeat (2000) @(posedge clk_sys);
    num_errors++;
    summarize();
  end
  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [15:0] s, e);
    comparisons++;
    num_errors += int'(s !== e);
    if (s !== e) $display("Error %0t %h %h", $time, s, e);
  endtask : check
  // Holds a request until taken, then waits for its answer.
  task automatic op(input logic w, input logic [1:0] ln,
    input logic [17:0] a, input logic [15:0] d);
    @(posedge clk_sys) #1;
    reqValid = 1'b1;
    req = '{w, ln, a, d};
    while (reqReady !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    reqValid = 1'b0;
    while (rspValid !== 1'b1) @(posedge clk_sys) #1;
  endtask : op
  task automatic lanes();
    op(1'b1, 2'h3, 18'h3FFFF, 16'hA55A);
    op(1'b1, 2'h2, 18'h3FFFF, 16'h1234);
    op(1'b1, 2'h0, 18'h3FFFF, 16'hFFFF);
    op(1'b0, 2'h1, 18'h3FFFF, 16'h0000);
    check(rspData, 16'h005A);
    op(1'b0, 2'h3, 18'h3FFFF, 16'h0000);
    check(rspData, 16'h125A);
    check({15'h0000, standby}, 16'h0000);
    repeat (7) @(posedge clk_sys) #1;
    check({15'h0000, standby}, 16'h0000);
    @(posedge clk_sys) #1;
    check({15'h0000, standby}, 16'h0001);
  endtask : lanes
  // A second word must not disturb the first.
  task automatic addresses();
    op(1'b1, 2'h3, 18'h00001, 16'h0F0F);
    op(1'b0, 2'h3, 18'h00001, 16'h0000);
    check(rspData, 16'h0F0F);
    op(1'b0, 2'h2, 18'h3FFFF, 16'h0000);
    check(rspData, 16'h1200);
  endtask : addresses
  // Reset, then the access sequence.
  initial begin
    #1 nrst = 1'b0;
    repeat (20) @(posedge clk_sys) #1;
    check(dqOe, 16'h0000);
    check({15'h0000, standby}, 16'h0001);
    nrst = 1'b1;
    lanes();
    addresses();
    summarize();
  end
endmodule : async_sram_byte_lane_access_test
`default_nettype wire
